// ===== hdl/scs_pkg.sv
// Constants, types and helpers shared by the serial channel status block
package scs_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_SUM   = 8'h04;
  localparam logic [7:0] OFS_PIE   = 8'h08;
  localparam logic [7:0] OFS_LEE   = 8'h0C;
  localparam logic [7:0] OFS_REE   = 8'h10;
  localparam logic [7:0] OFS_FIE   = 8'h14;
  localparam logic [7:0] OFS_TLO   = 8'h18;
  localparam logic [7:0] OFS_THI   = 8'h1C;
  localparam logic [7:0] OFS_RLV   = 8'h20;
  localparam logic [7:0] OFS_LSS   = 8'h24;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_NOP   = 8'h00;
  localparam logic [7:0] CMD_CHK   = 8'h18;
  localparam logic [7:0] CMD_CRST  = 8'h21;
  localparam logic [7:0] CMD_PLL_SEARCH_FLAG  = 8'h31;

  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int          SUM_TXI  = 7;
  localparam int          SUM_RXI  = 6;
  localparam int          SUM_TXR  = 1;
  localparam int          SUM_RXR  = 0;
  localparam logic [7:0] SUM_USED  = 8'hC3;
  localparam logic [7:0] TX_LE_M   = 8'hC8;
  localparam logic [7:0] RX_LE_M   = 8'h37;
  localparam logic [7:0] RX_RE_M   = 8'hFC;
  localparam logic [7:0] RX_FR_M   = 8'h80;
  localparam int          UDR_BIT  = 7;
  localparam int          LSS_PLL_SEARCH_FLAG = 0;
  localparam int          LSS_CHKE = 1;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] RST_EN    = 8'h00;
  localparam logic [4:0] RST_TLO   = 5'h00;
  localparam logic [4:0] RST_THI   = 5'h1F;
  localparam logic [4:0] RST_RLV   = 5'h00;
  localparam logic [4:0] THI_MAX   = 5'h1F;
  localparam int          CHK_CYC  = 15;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_GOOD = 16'h1D0F;

  typedef struct packed {
    logic [7:0] line_event;
    logic [7:0] receive_error;
    logic [7:0] frame;
  } scs_flags_t;

  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_RUN  = 2'b01,
    CHK_HOLD = 2'b11
  } scs_chk_t;

  // Any flag set together with its enable
  function automatic logic any_set(input logic [7:0] f, input logic [7:0] e, input logic [7:0] m);
    any_set = |(f & e & m);
  endfunction

  // Check sum over one byte, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    crc_byte = r;
  endfunction

endpackage

// ===== hdl/scs_check_calc.sv
// Forced receive check calculation with timed error presentation
`timescale 1ns/1ps
`default_nettype none
module scs_check_calc (
  input  wire logic        hclk,      // System clock
  input  wire logic        hresetn,   // Async reset, low
  input  wire logic        start,     // Forced check command pulse
  input  wire logic        clear,     // Channel reset pulse
  input  wire logic [7:0]  delay_data, // Receive delay byte
  input  wire logic [15:0] crc_acc,   // Running check accumulator
  input  wire logic        rx_enter,  // Next data enters buffer
  output logic             chk_err    // Check error status
);
  scs_pkg::scs_chk_t st, next_st;
  logic [3:0]  cnt, next_cnt;
  logic [15:0] res, next_res;
  logic        next_err;

  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    next_res = res;
    next_err = chk_err;
    if (rx_enter) next_err = 1'b0;
    unique case (st)
      scs_pkg::CHK_IDLE, scs_pkg::CHK_HOLD: ;
      scs_pkg::CHK_RUN: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          next_st  = scs_pkg::CHK_HOLD;
          next_err = (res != scs_pkg::CRC_GOOD);
        end
      end
    endcase
    if (start) begin
      // Whole byte in one step, so a halted receive clock cannot stall it
      next_st  = scs_pkg::CHK_RUN;
      next_cnt = 4'(scs_pkg::CHK_CYC - 2);
      next_res = scs_pkg::crc_byte(crc_acc, delay_data);
    end
    if (clear) begin
      next_st  = scs_pkg::CHK_IDLE;
      next_err = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st      <= scs_pkg::CHK_IDLE;
      cnt     <= 4'h0;
      res     <= scs_pkg::CRC_SEED;
      chk_err <= 1'b0;
    end else begin
      st      <= next_st;
      cnt     <= next_cnt;
      res     <= next_res;
      chk_err <= next_err;
    end
  end

  property p_chk_time;
    @(posedge hclk) disable iff (!hresetn)
    (start && !clear) ##1 (!start && !clear) [*8] ##1 (!start && !clear) [*6]
      |=> st == scs_pkg::CHK_HOLD;
  endproperty
  a_chk_time: assert property (p_chk_time) else $error("check result not ready in time");
endmodule
`default_nettype wire

// ===== hdl/scs_ready_flags.sv
// Transmit and receive ready flags with threshold hysteresis
`timescale 1ns/1ps
`default_nettype none
module scs_ready_flags #(
  parameter int CW = 6              // Buffer count width
) (
  input  wire logic          hclk,     // System clock
  input  wire logic          hresetn,  // Async reset, low
  input  wire logic          clear,    // Channel reset pulse
  input  wire logic          tx_en,    // Transmitter enabled
  input  wire logic          udr,      // Underrun flag
  input  wire logic [CW-1:0] tx_cnt,   // Transmit buffer bytes
  input  wire logic [4:0]    tx_lo,    // Low threshold
  input  wire logic [4:0]    tx_hi,    // High threshold
  input  wire logic [CW-1:0] rx_cnt,   // Receive buffer bytes
  input  wire logic [4:0]    rx_lv,    // Receive threshold
  input  wire logic          bit_sync, // Bit synchronous mode
  input  wire logic          eom_in,   // Frame-end data entered
  output logic               tx_rdy,   // Transmit space flag
  output logic               rx_rdy    // Receive data flag
);
  logic next_tx, next_rx;

  always_comb begin
    next_tx = tx_rdy;
    if (!tx_en || udr || clear) next_tx = 1'b0;
    else if (tx_cnt <= CW'(tx_lo)) next_tx = 1'b1;
    else if (tx_cnt >= CW'(tx_hi) + CW'(1)) next_tx = 1'b0;
    next_rx = rx_rdy;
    if (rx_cnt == '0) next_rx = 1'b0;
    if (rx_cnt >= CW'(rx_lv) + CW'(1) || (bit_sync && eom_in)) next_rx = 1'b1;
    if (clear) next_rx = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_rdy <= 1'b0;
      rx_rdy <= 1'b0;
    end else begin
      tx_rdy <= next_tx;
      rx_rdy <= next_rx;
    end
  end

  property p_tx_off;
    @(posedge hclk) disable iff (!hresetn)
    (!tx_en || udr) |=> !tx_rdy;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx ready while disabled");

  property p_tx_hyst;
    @(posedge hclk) disable iff (!hresetn)
    (tx_en && !udr && !clear && tx_cnt > CW'(tx_lo) && tx_cnt <= CW'(tx_hi)) |=> tx_rdy == $past(tx_rdy);
  endproperty
  a_tx_hyst: assert property (p_tx_hyst) else $error("tx ready lost hysteresis");

  property p_rx_hold;
    @(posedge hclk) disable iff (!hresetn)
    (rx_rdy && rx_cnt != '0 && !clear) |=> rx_rdy;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx ready dropped early");
endmodule
`default_nettype wire

// ===== hdl/scs_status_top.sv
// Serial channel status summary, commands and AHB-Lite register slave
// ****************************************
// Overview of operation
// - Command 18H starts the check over the receive delay byte at once.
// - Check error shows 15 clocks after 18H, held until next receive data.
// - Command 21H resets channel registers, disables both sides, empties buffers.
// - Command 31H puts clock recovery in search and sets the search flag.
// - Command 00H changes nothing.
// - Summary clears on hardware reset, channel reset and system stop.
// - Any summary bit with its enable set raises the host interrupt.
// - Transmit summary bit 7 is OR of enabled underrun, quiet, CTS change.
// - Transmit summary request needs its primary enable set.
// - Receive summary bit 6 ORs enabled line, error and frame read-out flags.
// - Receive summary request needs its primary enable set.
// - Summary bits 5 to 2 always read zero.
// - Transmit ready sets when enabled and count at or below low threshold.
// - Transmit ready clears at high threshold plus one, otherwise holds.
// - Transmit ready is zero when disabled or after underrun.
// - Transmit ready with enable interrupts; transmit ready alone requests DMA.
// - High threshold 31 with host word write drops the second byte.
// - Receive ready sets at threshold plus one bytes or, in bit synchronous mode, frame-end data.
// - Receive ready holds until the receive buffer is empty.
// - Receive ready with enable interrupts; receive ready alone requests DMA.
// ****************************************
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module scs_status_top #(
  parameter int CW = 6                   // Buffer count width
) (
  input  wire logic               hclk,      // System clock
  input  wire logic               hresetn,   // Async reset, low
  input  wire logic               hsel,      // Slave select
  input  wire logic [31:0]        haddr,     // Byte address
  input  wire logic [1:0]         htrans,    // Transfer type
  input  wire logic               hwrite,    // Write access
  input  wire logic [2:0]         hsize,     // Transfer size
  input  wire logic               hready,    // Bus ready in
  input  wire logic [31:0]        hwdata,    // Write data
  output logic [31:0]             hrdata,    // Read data
  output logic                    hreadyout, // Slave ready
  output logic                    hresp,     // Always OKAY
  input  wire scs_pkg::scs_flags_t flags,    // Line, error, frame flags
  input  wire logic               tx_en,     // Transmitter enabled
  input  wire logic [CW-1:0]      tx_cnt,    // Transmit buffer bytes
  input  wire logic [CW-1:0]      rx_cnt,    // Receive buffer bytes
  input  wire logic               bit_sync,  // Bit synchronous mode
  input  wire logic               eom_in,    // Frame-end data entered
  input  wire logic               rx_enter,  // Data entered receive buffer
  input  wire logic [7:0]         delay_data, // Receive delay byte
  input  wire logic [15:0]        crc_acc,   // Check accumulator
  input  wire logic               stop_mode, // System stop mode
  input  wire logic               pll_lock,  // Recovery loop locked
  input  wire logic               word_wr,   // Host word write to data port
  output logic                    irq,       // Interrupt request
  output logic                    tx_dma_req, // Transmit DMA request
  output logic                    rx_dma_req, // Receive DMA request
  output logic                    chan_reset, // Channel reset pulse
  output logic                    search_go, // Search mode pulse
  output logic                    check_error, // Check error status
  output logic                    tail_drop  // Second byte dropped
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic       wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic       acc;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] pie, next_pie;
  logic [7:0] lee, next_lee;
  logic [7:0] ree, next_ree;
  logic [7:0] frame_irq_enables, next_fie;
  logic [4:0] tlo, next_tlo;
  logic [4:0] thi, next_thi;
  logic [4:0] rlv, next_rlv;
  logic       pll_search_flag, next_pll_search_flag;
  logic [7:0] sum, next_sum;
  logic       next_irq;
  logic       next_crst;
  logic       next_sgo;
  logic       next_drop;
  logic       chk_go, next_chk_go;
  logic       tx_rdy, rx_rdy;
  logic       chk_err;
  logic       cmd_wr;
  logic [7:0] cmd;

  assign acc = hsel && htrans[1] && hready;
  assign cmd_wr = wr_pend && (wr_addr == scs_pkg::OFS_CMD);
  assign cmd = hwdata[7:0];

  // Read data is registered at the address phase so no wait state is needed
  always_comb begin
    next_wr_pend = acc && hwrite;
    next_wr_addr = acc ? haddr[7:0] : wr_addr;
    next_hrdata  = 32'h0000_0000;
    if (acc && !hwrite && haddr[31:8] == 24'h00_0000) begin
      unique case (haddr[7:0])
        scs_pkg::OFS_SUM: next_hrdata = {24'h00_0000, sum & scs_pkg::SUM_USED};
        scs_pkg::OFS_PIE: next_hrdata = {24'h00_0000, pie};
        scs_pkg::OFS_LEE: next_hrdata = {24'h00_0000, lee};
        scs_pkg::OFS_REE: next_hrdata = {24'h00_0000, ree};
        scs_pkg::OFS_FIE: next_hrdata = {24'h00_0000, frame_irq_enables};
        scs_pkg::OFS_TLO: next_hrdata = {27'h000_0000, tlo};
        scs_pkg::OFS_THI: next_hrdata = {27'h000_0000, thi};
        scs_pkg::OFS_RLV: next_hrdata = {27'h000_0000, rlv};
        scs_pkg::OFS_LSS: next_hrdata = {30'h0000_0000, chk_err, pll_search_flag};
        default:          next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************
  // Commands and control registers
  // ****************************************
  always_comb begin
    next_pie    = pie;
    next_lee    = lee;
    next_ree    = ree;
    next_fie    = frame_irq_enables;
    next_tlo    = tlo;
    next_thi    = thi;
    next_rlv    = rlv;
    next_pll_search_flag   = pll_search_flag;
    next_crst   = 1'b0;
    next_sgo    = 1'b0;
    next_chk_go = 1'b0;
    if (pll_lock) next_pll_search_flag = 1'b0;
    if (wr_pend) begin
      unique case (wr_addr)
        scs_pkg::OFS_PIE: next_pie = hwdata[7:0];
        scs_pkg::OFS_LEE: next_lee = hwdata[7:0];
        scs_pkg::OFS_REE: next_ree = hwdata[7:0];
        scs_pkg::OFS_FIE: next_fie = hwdata[7:0];
        scs_pkg::OFS_TLO: next_tlo = hwdata[4:0];
        scs_pkg::OFS_THI: next_thi = hwdata[4:0];
        scs_pkg::OFS_RLV: next_rlv = hwdata[4:0];
        default: ; // Summary writes are ignored
      endcase
    end
    if (cmd_wr) begin
      unique case (cmd)
        scs_pkg::CMD_CHK: next_chk_go = 1'b1;
        scs_pkg::CMD_PLL_SEARCH_FLAG: begin
          next_sgo  = 1'b1;
          next_pll_search_flag = 1'b1;
        end
        scs_pkg::CMD_CRST: begin
          // Outer channel logic disables both sides and empties buffers
          next_crst = 1'b1;
          next_pie  = scs_pkg::RST_EN;
          next_lee  = scs_pkg::RST_EN;
          next_ree  = scs_pkg::RST_EN;
          next_fie  = scs_pkg::RST_EN;
          next_tlo  = scs_pkg::RST_TLO;
          next_thi  = scs_pkg::RST_THI;
          next_rlv  = scs_pkg::RST_RLV;
          next_pll_search_flag = 1'b0;
        end
        default: ; // No operation and unknown codes leave all running
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pie        <= scs_pkg::RST_EN;
      lee        <= scs_pkg::RST_EN;
      ree        <= scs_pkg::RST_EN;
      frame_irq_enables        <= scs_pkg::RST_EN;
      tlo        <= scs_pkg::RST_TLO;
      thi        <= scs_pkg::RST_THI;
      rlv        <= scs_pkg::RST_RLV;
      pll_search_flag       <= 1'b0;
      chan_reset <= 1'b0;
      search_go  <= 1'b0;
      chk_go     <= 1'b0;
    end else begin
      pie        <= next_pie;
      lee        <= next_lee;
      ree        <= next_ree;
      frame_irq_enables        <= next_fie;
      tlo        <= next_tlo;
      thi        <= next_thi;
      rlv        <= next_rlv;
      pll_search_flag       <= next_pll_search_flag;
      chan_reset <= next_crst;
      search_go  <= next_sgo;
      chk_go     <= next_chk_go;
    end
  end

  // ****************************************
  // Sub-blocks
  // ****************************************
  scs_check_calc u_chk (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .start      (chk_go),
    .clear      (chan_reset),
    .delay_data (delay_data),
    .crc_acc    (crc_acc),
    .rx_enter   (rx_enter),
    .chk_err    (chk_err)
  );

  scs_ready_flags #(.CW(CW)) u_rdy (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clear    (chan_reset),
    .tx_en    (tx_en),
    .udr      (flags.line_event[scs_pkg::UDR_BIT]),
    .tx_cnt   (tx_cnt),
    .tx_lo    (tlo),
    .tx_hi    (thi),
    .rx_cnt   (rx_cnt),
    .rx_lv    (rlv),
    .bit_sync (bit_sync),
    .eom_in   (eom_in),
    .tx_rdy   (tx_rdy),
    .rx_rdy   (rx_rdy)
  );

  // ****************************************
  // Summary status and requests
  // ****************************************
  always_comb begin
    next_sum = 8'h00;
    next_sum[scs_pkg::SUM_TXI] = scs_pkg::any_set(flags.line_event, lee, scs_pkg::TX_LE_M);
    next_sum[scs_pkg::SUM_RXI] = scs_pkg::any_set(flags.line_event, lee, scs_pkg::RX_LE_M)
                               | scs_pkg::any_set(flags.receive_error, ree, scs_pkg::RX_RE_M)
                               | scs_pkg::any_set(flags.frame, frame_irq_enables, scs_pkg::RX_FR_M);
    next_sum[scs_pkg::SUM_TXR] = tx_rdy;
    next_sum[scs_pkg::SUM_RXR] = rx_rdy;
    if (stop_mode || chan_reset) next_sum = 8'h00;
    // Each bit needs its own primary enable; bits 7,6,1,0 share positions
    // Next enables too, so a write to the enables cannot leave irq one cycle stale
    next_irq  = scs_pkg::any_set(next_sum, next_pie, scs_pkg::SUM_USED);
    // Buffer drops the byte on its own; this only reports it
    next_drop = word_wr && (thi == scs_pkg::THI_MAX);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum         <= 8'h00;
      irq         <= 1'b0;
      tx_dma_req  <= 1'b0;
      rx_dma_req  <= 1'b0;
      tail_drop   <= 1'b0;
      check_error <= 1'b0;
    end else begin
      sum         <= next_sum;
      irq         <= next_irq;
      tx_dma_req  <= next_sum[scs_pkg::SUM_TXR];
      rx_dma_req  <= next_sum[scs_pkg::SUM_RXR];
      tail_drop   <= next_drop;
      check_error <= chk_err;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_sum_clr;
    @(posedge hclk) disable iff (!hresetn)
    (stop_mode || chan_reset) |=> sum == 8'h00;
  endproperty
  a_sum_clr: assert property (p_sum_clr) else $error("summary not cleared");

  property p_rsv;
    @(posedge hclk) disable iff (!hresetn)
    sum[5:2] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved summary bits set");

  property p_txi;
    @(posedge hclk) disable iff (!hresetn)
    (!stop_mode && !chan_reset && |(flags.line_event & lee & scs_pkg::TX_LE_M)) |=> sum[scs_pkg::SUM_TXI];
  endproperty
  a_txi: assert property (p_txi) else $error("transmit summary missed");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    irq == |(sum & pie & scs_pkg::SUM_USED);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch with summary");

  property p_pll_search_flag;
    @(posedge hclk) disable iff (!hresetn)
    (cmd_wr && cmd == scs_pkg::CMD_PLL_SEARCH_FLAG) |=> pll_search_flag && search_go ##1 !search_go;
  endproperty
  a_pll_search_flag: assert property (p_pll_search_flag) else $error("search command not applied");

  property p_crst;
    @(posedge hclk) disable iff (!hresetn)
    (cmd_wr && cmd == scs_pkg::CMD_CRST) |=> chan_reset && pie == 8'h00 ##1 sum == 8'h00;
  endproperty
  a_crst: assert property (p_crst) else $error("channel reset not applied");

  property p_nop;
    @(posedge hclk) disable iff (!hresetn)
    (cmd_wr && cmd == scs_pkg::CMD_NOP) |=> !chan_reset && !search_go && !chk_go;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op had an effect");

  property p_dma;
    @(posedge hclk) disable iff (!hresetn)
    tx_dma_req == sum[scs_pkg::SUM_TXR] && rx_dma_req == sum[scs_pkg::SUM_RXR];
  endproperty
  a_dma: assert property (p_dma) else $error("dma request mismatch");

endmodule
`default_nettype wire

// ===== bench/scs_dma_model.sv
// DMA engine and buffer fill model facing the status block
`timescale 1ns/1ps
`default_nettype none
module scs_dma_model (
  input  wire logic       hclk,    // System clock
  input  wire logic       hresetn, // Async reset, low
  input  wire logic       run,     // DMA engine active
  input  wire logic       fill,    // Line delivers a byte
  input  wire logic       drain,   // Transmitter sends a byte
  input  wire logic       clr,     // Channel reset empties buffers
  input  wire logic       tx_req,  // Transmit DMA request
  input  wire logic       rx_req,  // Receive DMA request
  output logic [5:0]      tx_cnt,  // Transmit buffer bytes
  output logic [5:0]      rx_cnt   // Receive buffer bytes
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt <= 6'h00;
      rx_cnt <= 6'h00;
    end else if (clr) begin
      tx_cnt <= 6'h00;
      rx_cnt <= 6'h00;
    end else begin
      // Stops on the request edge, so two bytes may land late like a real engine
      if (run && tx_req) tx_cnt <= tx_cnt + 6'h01;
      else if (drain && tx_cnt != 6'h00) tx_cnt <= tx_cnt - 6'h01;
      if (fill) rx_cnt <= rx_cnt + 6'h01;
      else if (run && rx_req && rx_cnt != 6'h00) rx_cnt <= rx_cnt - 6'h01;
    end
  end
endmodule
`default_nettype wire

// ===== bench/serial_channel_status_commands_tb.sv
// Self-checking bench for the serial channel status block
`timescale 1ns/1ps
`default_nettype none
module serial_channel_status_commands_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, tx_en, bit_sync, eom_in, rx_enter;
  logic stop_mode, word_wr, irq, tx_dma_req, rx_dma_req, chan_reset, search_go, check_error, tail_drop;
  logic run, fill, drain;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [5:0]  tx_cnt, rx_cnt;
  logic [7:0]  delay_data;
  logic [15:0] crc_acc;
  scs_pkg::scs_flags_t flags;
  int          err_total, n_checks;
  logic [23:0] fv [8] = '{24'h08_0000, 24'h40_0000, 24'h80_0000, 24'h20_0000,
                          24'h17_0000, 24'h00_0400, 24'h00_0080, 24'h00_037F};
  logic [7:0]  ev [8] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h40, 8'h40, 8'h40, 8'h00};
  assign hready = hreadyout;
  scs_status_top #(.CW(6)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .flags, .tx_en, .tx_cnt, .rx_cnt, .bit_sync, .eom_in, .rx_enter,
    .delay_data, .crc_acc, .stop_mode, .pll_lock(1'b0), .word_wr, .irq, .tx_dma_req,
    .rx_dma_req, .chan_reset, .search_go, .check_error, .tail_drop);
  scs_dma_model part (.hclk, .hresetn, .run, .fill, .drain, .clr(chan_reset), .tx_req(tx_dma_req),
    .rx_req(rx_dma_req), .tx_cnt, .rx_cnt);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task cy(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // Bounded waits: a hung handshake or count ends the run
  task wt;
    int k;
    k = 0;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 20);
    if (k >= 20) begin err_total++; summarize; end
  endtask
  task wcnt(input bit s, input int v);
    int k;
    k = 0;
    do begin cy(1); k++; end while ((s ? rx_cnt : tx_cnt) !== v && k < 300);
    if (k >= 300) begin err_total++; summarize; end
  endtask
  task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a; hwrite <= w; hsel <= 1'b1; htrans <= 2'b10;
    wt;
    htrans <= 2'b00; hwdata <= d;
    wt;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk("rdata", e, hrdata);
  endtask
  task t_reset;
    rd(32'h04, 32'h0);
    rd(32'h1C, 32'h1F);
    rd(32'h40, 32'h0);
    chk("hresp", 1'b0, hresp);
  endtask
  task t_sum;
    wr(32'h0C, 32'hFF); wr(32'h10, 32'hFF); wr(32'h14, 32'hFF); wr(32'h08, 32'hC3);
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk); flags <= scs_pkg::scs_flags_t'(fv[i]);
      rd(32'h04, {24'h0, ev[i]});
      chk("irq", |ev[i], irq);
    end
    wr(32'h04, 32'hFF); rd(32'h04, 32'h0);
    @(posedge hclk); flags <= 24'h08_0000; stop_mode <= 1'b1;
    rd(32'h04, 32'h0);
    @(posedge hclk); stop_mode <= 1'b0; wr(32'h08, 32'h40); cy(2);
    chk("irq", 1'b0, irq);
    @(posedge hclk); flags <= 24'h00_0400; wr(32'h08, 32'h80); cy(2);
    chk("irq", 1'b0, irq);
    @(posedge hclk); flags <= 24'h0;
  endtask
  task t_tx;
    wr(32'h18, 32'h04); wr(32'h1C, 32'h0A);
    @(posedge hclk); tx_en <= 1'b1; run <= 1'b1;
    wcnt(0, 11); cy(3);
    chk("txreq", 1'b0, tx_dma_req);
    run <= 1'b0; drain <= 1'b1; wcnt(0, 5); drain <= 1'b0; cy(3);
    chk("txreq", 1'b0, tx_dma_req);
    drain <= 1'b1; wcnt(0, 4); drain <= 1'b0; cy(2);
    chk("txreq", 1'b1, tx_dma_req);
    rd(32'h04, 32'h02);
    flags <= 24'h80_0000; cy(2);
    chk("txreq", 1'b0, tx_dma_req);
    flags <= 24'h0; cy(2); tx_en <= 1'b0; cy(2);
    chk("txreq", 1'b0, tx_dma_req);
    wr(32'h1C, 32'h1F); word_wr <= 1'b1; cy(1); word_wr <= 1'b0;
    chk("drop", 1'b1, tail_drop);
  endtask
  task t_rx;
    wr(32'h20, 32'h03);
    fill <= 1'b1; wcnt(1, 3); fill <= 1'b0; cy(2);
    chk("rxreq", 1'b0, rx_dma_req);
    fill <= 1'b1; cy(1); fill <= 1'b0; cy(2);
    chk("rxreq", 1'b1, rx_dma_req);
    run <= 1'b1; wcnt(1, 1);
    chk("rxreq", 1'b1, rx_dma_req);
    wcnt(1, 0); run <= 1'b0; cy(2);
    chk("rxreq", 1'b0, rx_dma_req);
    bit_sync <= 1'b1; fill <= 1'b1; eom_in <= 1'b1; cy(1); fill <= 1'b0; eom_in <= 1'b0; cy(2);
    chk("rxreq", 1'b1, rx_dma_req);
  endtask
  task t_cmd;
    wr(32'h00, 32'h31); #1; chk("search", 1'b1, search_go);
    rd(32'h24, 32'h1);
    wr(32'h00, 32'h00); rd(32'h24, 32'h1);
    wr(32'h00, 32'h18); cy(15);
    chk("chkerr", 1'b0, check_error);
    cy(1); chk("chkerr", 1'b1, check_error);
    rx_enter <= 1'b1; cy(1); rx_enter <= 1'b0; cy(2);
    chk("chkerr", 1'b0, check_error);
    // Byte and accumulator chosen so the check ends on the good residue
    delay_data <= 8'h12; crc_acc <= 16'hF3F0; wr(32'h00, 32'h18); cy(16);
    chk("chkerr", 1'b0, check_error);
    wr(32'h00, 32'h21); #1; chk("creset", 1'b1, chan_reset);
    cy(2); chk("rxcnt", 6'h0, rx_cnt);
    rd(32'h24, 32'h0); rd(32'h08, 32'h0); rd(32'h20, 32'h0);
    rd(32'h04, 32'h0);
  endtask
  initial begin
    {hsel, hwrite, tx_en, bit_sync, eom_in, rx_enter, stop_mode, word_wr, run, fill, drain} = '0;
    {haddr, hwdata, htrans, flags, err_total, n_checks, delay_data, crc_acc} = '0;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset; t_sum; t_tx; t_rx; t_cmd;
    summarize;
  end
endmodule
`default_nettype wire
